// File: core/cpm_pkg.sv
// Purpose: shared constants for the call-progress pwm output block
// Assumes: 250 MHz sys_clk, 8-bit register port
// Notes: register offsets, field positions, reset values and timing
package cpm_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CPM_ADDR_TONE_CTRL = 8'h01;
  localparam logic [7:0] CPM_ADDR_IRQ_PIN = 8'h02;
  localparam logic [7:0] CPM_ADDR_RX_GAIN = 8'h14;
  localparam logic [7:0] CPM_ADDR_TX_GAIN = 8'h15;
  localparam logic [7:0] CPM_ADDR_STATUS = 8'h30;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CPM_MODE_LSB = 4;
  localparam int CPM_PWM_EN_BIT = 3;
  localparam int CPM_IRQ_EN_BIT = 0;
  localparam logic [1:0] CPM_MODE_RST = 2'h0;
  localparam logic CPM_PWM_EN_RST = 1'b0;
  localparam logic CPM_IRQ_EN_RST = 1'b0;
  localparam logic [7:0] CPM_GAIN_RST = 8'h00;

  // ------------------------------------------------------------
  // output encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CPM_MODE_DSM = 2'h0,
    CPM_MODE_RZ = 2'h1,
    CPM_MODE_BAL = 2'h2
  } cpm_mode_e;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CPM_CLK_HZ = 250_000_000;
  localparam int CPM_PWM_FREQ_HZ = 32_000;
  localparam int CPM_PWM_PERIOD_CYC = CPM_CLK_HZ / CPM_PWM_FREQ_HZ;

endpackage

// File: core/cpm_encoder.sv
// Purpose: turns an unsigned level into one of three pin encodings
// Assumes: level is held by the caller between updates
// Notes: duty is latched at each period start so pulses never tear
`timescale 1ns/1ns
module cpm_encoder #(
  parameter int PERIOD_CYC = cpm_pkg::CPM_PWM_PERIOD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire cpm_pkg::cpm_mode_e mode,
  input wire logic [15:0] level,
  output logic pwm_bit
);

  if (PERIOD_CYC < 2 || PERIOD_CYC > 65535) begin : g_chk
    $error("cpm_encoder: PERIOD_CYC out of range");
  end

  localparam logic [15:0] LAST = 16'(PERIOD_CYC - 1);
  localparam logic [31:0] PER32 = 32'(PERIOD_CYC);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] duty;
    logic [15:0] lo;
    logic [15:0] acc;
    logic bit_q;
  } cpm_enc_s;

  cpm_enc_s r_reg;
  cpm_enc_s r_next;
  logic [31:0] prod;
  logic [16:0] sum;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    prod = {16'h0000, level} * PER32;
    sum = {1'b0, r_reg.acc} + {1'b0, level};
    r_next.cnt = (r_reg.cnt == LAST) ? 16'h0000 : r_reg.cnt + 16'h0001;
    if (r_reg.cnt == LAST) begin
      r_next.duty = prod[31:16];
      r_next.lo = 16'((PER32 - {16'h0000, prod[31:16]}) >> 1);
    end
    // first-order delta-sigma: carry out is the bit stream
    r_next.acc = sum[15:0];
    case (mode)  // see RULE5
      cpm_pkg::CPM_MODE_RZ: r_next.bit_q = (r_reg.cnt < r_reg.duty);
      cpm_pkg::CPM_MODE_BAL: r_next.bit_q = (r_reg.cnt >= r_reg.lo) &&
                                            (r_reg.cnt < r_reg.lo + r_reg.duty);
      default: r_next.bit_q = sum[16];
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pwm_bit = r_reg.bit_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_rz_shape;
    @(posedge sys_clk) disable iff (!rst_n)
      mode == cpm_pkg::CPM_MODE_RZ |=> pwm_bit == ($past(r_reg.cnt) < $past(r_reg.duty));
  endproperty
  a_rz_shape: assert property (p_rz_shape) else $error("rz pulse mismatch"); // see RULE5

  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      r_reg.cnt == LAST |=> r_reg.cnt == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("period counter did not wrap"); // see RULE5

endmodule

// File: core/cpm_call_progress_pwm.sv
// Purpose: call-progress monitor output, mixing scaled rx and tx audio
// Assumes: samples come from logic on sys_clk, no synchroniser needed
// Notes: pin is driven only while pwm is on and irq pin use is off
//
// Summary of operation
// RULE1 - software clears irq_output_enable, sets pwm_out_enable and writes mode 00 to use the pin; the code drives the pin in every mode.
// RULE2 - rx and tx contributions are each scaled linearly by their gain registers at 0x14 and 0x15.
// RULE3 - a gain of all zeros fully mutes that contribution.
// RULE4 - gains touch only the monitor output, never the line-side sample paths.
// RULE5 - mode bits 5:4 of register 0x01 pick delta-sigma, 32 kHz rz pwm or balanced pwm.
// RULE6 - after reset every register holds its default value.
// RULE7 - codes 01 and 10 select rz and balanced pwm; code 11 acts as 00.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
module cpm_call_progress_pwm #(
  parameter int PERIOD_CYC = cpm_pkg::CPM_PWM_PERIOD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic signed [15:0] rx_sample,
  input wire logic signed [15:0] tx_sample,
  output logic signed [15:0] rx_line_data,
  output logic signed [15:0] tx_line_data,
  output logic call_progress_out,
  output logic call_progress_oe
);

  typedef struct packed {
    logic [1:0] mode;
    logic pwm_en;
    logic irq_en;
    logic [7:0] rx_gain;
    logic [7:0] tx_gain;
    logic [15:0] mix;
    logic [15:0] rx_line;
    logic [15:0] tx_line;
    logic [7:0] rdata;
    logic pin;
    logic pin_oe;
  } cpm_top_s;

  localparam cpm_top_s RST = '{
    mode: cpm_pkg::CPM_MODE_RST, pwm_en: cpm_pkg::CPM_PWM_EN_RST,
    irq_en: cpm_pkg::CPM_IRQ_EN_RST, rx_gain: cpm_pkg::CPM_GAIN_RST,
    tx_gain: cpm_pkg::CPM_GAIN_RST, default: '0};

  cpm_top_s r_reg;
  cpm_top_s r_next;
  cpm_pkg::cpm_mode_e enc_mode;
  logic enc_bit;
  logic pin_active;
  logic signed [24:0] rx_prod;
  logic signed [24:0] tx_prod;
  logic signed [25:0] sum;
  logic signed [17:0] scaled;

  // ------------------------------------------------------------
  // mixer and encoding select
  // ------------------------------------------------------------
  // linear scaling, gain/256 per path; zero gain yields zero product
  assign rx_prod = rx_sample * $signed({1'b0, r_reg.rx_gain});  // see RULE2 see RULE3
  assign tx_prod = tx_sample * $signed({1'b0, r_reg.tx_gain});  // see RULE2 see RULE3
  assign sum = 26'(rx_prod) + 26'(tx_prod);
  assign scaled = sum[25:8];

  always_comb begin
    case (r_reg.mode)  // see RULE7
      2'h1: enc_mode = cpm_pkg::CPM_MODE_RZ;
      2'h2: enc_mode = cpm_pkg::CPM_MODE_BAL;
      default: enc_mode = cpm_pkg::CPM_MODE_DSM;
    endcase
  end

  assign pin_active = r_reg.pwm_en && !r_reg.irq_en;  // see RULE1

  cpm_encoder #(
    .PERIOD_CYC(PERIOD_CYC)
  ) u_enc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .mode(enc_mode),
    .level(r_reg.mix ^ 16'h8000),
    .pwm_bit(enc_bit)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    if (sample_valid) begin
      if (scaled > 18'sh07FFF) begin
        r_next.mix = 16'h7FFF;
      end else if (scaled < -18'sh08000) begin
        r_next.mix = 16'h8000;
      end else begin
        r_next.mix = scaled[15:0];
      end
      // line paths bypass the gains entirely
      r_next.rx_line = rx_sample;  // see RULE4
      r_next.tx_line = tx_sample;  // see RULE4
    end
    r_next.pin_oe = pin_active;
    r_next.pin = pin_active && enc_bit;
    if (reg_wr) begin
      case (reg_addr)
        cpm_pkg::CPM_ADDR_TONE_CTRL: begin
          r_next.mode = reg_wdata[cpm_pkg::CPM_MODE_LSB +: 2];  // see RULE5
          r_next.pwm_en = reg_wdata[cpm_pkg::CPM_PWM_EN_BIT];
        end
        cpm_pkg::CPM_ADDR_IRQ_PIN: r_next.irq_en = reg_wdata[cpm_pkg::CPM_IRQ_EN_BIT];
        cpm_pkg::CPM_ADDR_RX_GAIN: r_next.rx_gain = reg_wdata;  // see RULE2
        cpm_pkg::CPM_ADDR_TX_GAIN: r_next.tx_gain = reg_wdata;  // see RULE2
        default: r_next.mode = r_reg.mode;
      endcase
    end
    r_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        cpm_pkg::CPM_ADDR_TONE_CTRL: begin
          r_next.rdata[cpm_pkg::CPM_MODE_LSB +: 2] = r_reg.mode;
          r_next.rdata[cpm_pkg::CPM_PWM_EN_BIT] = r_reg.pwm_en;
        end
        cpm_pkg::CPM_ADDR_IRQ_PIN: r_next.rdata[cpm_pkg::CPM_IRQ_EN_BIT] = r_reg.irq_en;
        cpm_pkg::CPM_ADDR_RX_GAIN: r_next.rdata = r_reg.rx_gain;
        cpm_pkg::CPM_ADDR_TX_GAIN: r_next.rdata = r_reg.tx_gain;
        cpm_pkg::CPM_ADDR_STATUS: r_next.rdata = {6'h00, r_reg.pin, r_reg.pin_oe};
        default: r_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r_reg <= RST;  // see RULE6
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata = r_reg.rdata;
  assign rx_line_data = r_reg.rx_line;
  assign tx_line_data = r_reg.tx_line;
  assign call_progress_out = r_reg.pin;
  assign call_progress_oe = r_reg.pin_oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_wr_rx;
    reg_wr && reg_addr == cpm_pkg::CPM_ADDR_RX_GAIN;
  endsequence
  sequence s_rd_rx;
    reg_rd && !reg_wr && reg_addr == cpm_pkg::CPM_ADDR_RX_GAIN;
  endsequence

  property p_gain_rw;
    @(posedge sys_clk) disable iff (!rst_n)
      s_wr_rx ##1 s_rd_rx |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_gain_rw: assert property (p_gain_rw) else $error("rx gain readback wrong"); // see RULE2

  property p_half_gain;
    @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && r_reg.rx_gain == 8'h00 && r_reg.tx_gain == 8'h80
      |=> $signed(r_reg.mix) == ($past(tx_sample) >>> 1);
  endproperty
  a_half_gain: assert property (p_half_gain) else $error("tx scaling not linear"); // see RULE2

  property p_mute;
    @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && r_reg.rx_gain == 8'h00 && r_reg.tx_gain == 8'h00 |=> r_reg.mix == 16'h0000;
  endproperty
  a_mute: assert property (p_mute) else $error("muted paths not silent"); // see RULE3

  property p_line;
    @(posedge sys_clk) disable iff (!rst_n)
      sample_valid |=> rx_line_data == $past(rx_sample) && tx_line_data == $past(tx_sample);
  endproperty
  a_line: assert property (p_line) else $error("line path altered"); // see RULE4

  property p_pin_off;
    @(posedge sys_clk) disable iff (!rst_n)
      !(r_reg.pwm_en && !r_reg.irq_en) |=> !call_progress_oe && !call_progress_out;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled"); // see RULE1

  property p_mode_map;
    @(posedge sys_clk) disable iff (!rst_n)
      r_reg.mode == 2'h3 |-> enc_mode == cpm_pkg::CPM_MODE_DSM;
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("reserved mode not as 00"); // see RULE7

  property p_mode_wr;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == cpm_pkg::CPM_ADDR_TONE_CTRL
      |=> r_reg.mode == $past(reg_wdata[5:4]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode field not stored"); // see RULE5

  property p_reset;
    @(posedge sys_clk) !rst_n |=> r_reg.mode == 2'h0 && !r_reg.pwm_en && !r_reg.irq_en &&
      r_reg.rx_gain == 8'h00 && r_reg.tx_gain == 8'h00 && !call_progress_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("registers not at default"); // see RULE6

  property p_pin_on;
    @(posedge sys_clk) disable iff (!rst_n)
      r_reg.pwm_en && !r_reg.irq_en |=> call_progress_oe;
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin not driven while enabled"); // see RULE1

  property p_rx_only;
    @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && r_reg.rx_gain == 8'h80 && r_reg.tx_gain == 8'h00
      |=> $signed(r_reg.mix) == ($past(rx_sample) >>> 1);
  endproperty
  a_rx_only: assert property (p_rx_only) else $error("rx scaling not linear"); // see RULE3

  property p_status;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_rd && reg_addr == cpm_pkg::CPM_ADDR_STATUS
      |=> reg_rdata == {6'h00, $past(call_progress_out), $past(call_progress_oe)};
  endproperty
  a_status: assert property (p_status) else $error("status read wrong"); // see RULE1

endmodule

// File: verification/cpm_speaker_model.sv
// Purpose: behavioural transistor stage that drives the call-progress speaker
// Assumes: the pin reaches the transistor base only while oe is high
// Notes: counts high cycles and rising edges over a fixed window
`timescale 1ns/1ns
module cpm_speaker_model #(
  parameter int WIN = 64
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic pin_oe,
  input wire logic start,
  output logic [15:0] highs,
  output logic [15:0] edges,
  output logic done
);
  logic base;
  logic prev;
  int left;
  // a released pin leaves the base pulled low by its bias resistor
  assign base = pin_oe ? pin : 1'b0;
  always @(posedge sys_clk) begin
    done <= 1'b0;
    prev <= base;
    if (!rst_n) begin
      left <= 0;
    end else if (start) begin
      left <= WIN;
      highs <= 16'h0000;
      edges <= 16'h0000;
    end else if (left > 0) begin
      highs <= highs + 16'(base);
      edges <= edges + 16'(base && !prev);
      left <= left - 1;
      done <= (left == 1);
    end
  end
endmodule

// File: verification/call_progress_pwm_output_bench.sv
// Purpose: self-checking bench for the call-progress pwm output block
// Assumes: short pwm period so that whole periods fit a small window
// Notes: drivers queue expectations, one monitor process compares them
`timescale 1ns/1ns
module call_progress_pwm_output_bench;
  localparam int PER = 16;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sample_valid = 1'b0;
  logic signed [15:0] rx_sample = 16'h0000;
  logic signed [15:0] tx_sample = 16'h0000;
  logic signed [15:0] rx_line_data;
  logic signed [15:0] tx_line_data;
  logic call_progress_out;
  logic call_progress_oe;
  logic start = 1'b0;
  logic [15:0] highs;
  logic [15:0] edges;
  logic done;
  logic rd_seen = 1'b0;
  logic sv_seen = 1'b0;
  logic [7:0] exp_rd[$];
  logic [31:0] exp_line[$];
  logic [31:0] exp_cnt[$];
  logic [7:0] addrs[4] = '{8'h01, 8'h02, 8'h14, 8'h15};
  logic [7:0] masks[4] = '{8'h38, 8'h01, 8'hFF, 8'hFF};
  int gr[4] = '{128, 0, 128, 0};
  int gt[4] = '{0, 128, 255, 0};
  int sr[4] = '{16384, 32767, 16384, 32767};
  int st[4] = '{32767, -4096, -4096, 32767};
  int fails = 0;
  int n_compared = 0;
  logic [7:0] v;
  int seed_val;
  always #2 sys_clk = ~sys_clk;
  cpm_call_progress_pwm #(.PERIOD_CYC(PER)) u_cpm_call_progress_pwm (.sys_clk(sys_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .rx_sample(rx_sample), .tx_sample(tx_sample), .rx_line_data(rx_line_data),
    .tx_line_data(tx_line_data), .call_progress_out(call_progress_out),
    .call_progress_oe(call_progress_oe));
  cpm_speaker_model #(.WIN(4 * PER)) u_cpm_speaker_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .pin(call_progress_out), .pin_oe(call_progress_oe), .start(start), .highs(highs),
    .edges(edges), .done(done));
  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task cmp_rdata(input logic [7:0] e);
    cmp("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
  endtask
  task cmp_line(input logic [31:0] e);
    cmp("line_data", e, {rx_line_data, tx_line_data});
  endtask
  task cmp_pin(input logic [31:0] e);
    cmp("pin_counts", e, {highs, edges});
  endtask
  task stop_test;
    // results that never showed up count as mismatches
    fails += exp_rd.size() + exp_line.size() + exp_cnt.size();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    rd_seen <= reg_rd;
    sv_seen <= sample_valid;
    if (rd_seen) cmp_rdata(exp_rd.pop_front());
    if (sv_seen) cmp_line(exp_line.pop_front());
    if (done) cmp_pin(exp_cnt.pop_front());
  end
  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    exp_rd.push_back(e);
    @(posedge sys_clk);
  endtask
  task idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    sample_valid <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task smp(input logic [15:0] r, input logic [15:0] t);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    rx_sample <= r;
    tx_sample <= t;
    sample_valid <= 1'b1;
    exp_line.push_back({r, t});
    @(posedge sys_clk);
  endtask
  task measure(input int hi, input int ed);
    int i;
    idle(3 * PER);
    start <= 1'b1;
    exp_cnt.push_back({16'(hi), 16'(ed)});
    @(posedge sys_clk);
    start <= 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge sys_clk);
    if (done !== 1'b1) begin
      fails++;
      stop_test();
    end
    @(posedge sys_clk);
  endtask
  function automatic int duty(int rg, int tg, int rx, int tx);
    int m;
    m = (rx * rg + tx * tg) >>> 8;
    return ((m + 32768) * PER) >>> 16;
  endfunction
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed_val = $urandom(61);
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h40, 8'h00);
    foreach (addrs[i]) begin
      v = 8'($urandom) & masks[i];
      wr(addrs[i], v);
      rd(addrs[i], v);
    end
    smp(16'($urandom), 16'($urandom));
    smp(16'($urandom), 16'($urandom));
    idle(1);
    wr(8'h02, 8'h01);
    wr(8'h01, 8'h08);
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h00);
    // fresh sample with both gains muted brings the mix to zero
    smp(16'($urandom), 16'($urandom));
    measure(0, 0);
    wr(8'h02, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(8'h01, 8'h08 | 8'(m << 4));
      measure(4 * PER / 2, (m == 1 || m == 2) ? 4 : 4 * PER / 2);
    end
    wr(8'h01, 8'h18);
    for (int r = 0; r < 4; r++) begin
      wr(8'h14, 8'(gr[r]));
      wr(8'h15, 8'(gt[r]));
      smp(16'(sr[r]), 16'(st[r]));
      measure(4 * duty(gr[r], gt[r], sr[r], st[r]), 4);
    end
    // reset in mid-run must bring every register back to default
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    rd(8'h30, 8'h00);
    idle(2);
    stop_test();
  end
endmodule
